// ===== sdac_core.sv
// Top of the converter front end: word decode, mode control and status
//
// Operation
// - A falling edge of the active-low frame select starts a new write.
// - While framed, data is sampled on the first 16 serial clock falls into a 16-bit shift register.
// - The 16th falling edge takes the last bit; code and mode are applied together once its toggle crosses into the system clock.
// - A frame that ends before the 16th edge is discarded: code and mode stay unchanged and abort_pulse fires.
// - The first two bits are ignored and the next two select the operating mode.
// - Mode bits decode 00 normal, 01 5k pulldown, 10 100k pulldown, 11 high impedance.
// - Any nonzero mode powers down bias, amplifier and string and picks the termination.
// - Reset loads a zero code so the output sits at zero until a full write.
// - The code is straight unsigned binary from 0 to 4095.
// - Code and mode are held without traffic until a new valid write.
`timescale 1ns/1ps
module sdac_core
    import sdac_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 srst,
    input  wire logic                 sclk,
    input  wire logic                 sync_n,
    input  wire logic                 din,
    output logic [CODE_BITS-1:0]      code,
    output logic [1:0]                mode,
    output logic                      power_down,
    output logic                      analog_en,
    output logic                      pulldown_5k,
    output logic                      pulldown_100k,
    output logic                      out_hiz,
    output logic                      code_full,
    output logic                      update_pulse,
    output logic                      abort_pulse,
    output logic                      frame_busy
);

    // Word and event toggle from the serial clock domain
    sdac_link_if lnk ();

    // Shifter clocked by the serial clock
    sdac_shift sdac_shift_i (
        .sclk   (sclk),
        .sync_n (sync_n),
        .din    (din),
        .srst   (srst),
        .lnk    (lnk)
    );

    // Synchroniser stages, stage 0 newest
    logic [SYNC_STAGES-1:0] fs_sync_reg;
    logic [SYNC_STAGES-1:0] fs_sync_next;
    logic [2:0]             tg_sync_reg;
    logic [2:0]             tg_sync_next;
    // Frame tracking state
    sdac_state_t            state_reg;
    sdac_state_t            state_next;
    // Applied code and mode
    logic [CODE_BITS-1:0]   code_reg;
    logic [CODE_BITS-1:0]   code_next;
    sdac_mode_t             mode_reg;
    sdac_mode_t             mode_next;
    // Power and termination controls
    logic                   pd_reg;
    logic                   pd_next;
    logic                   aen_reg;
    logic                   aen_next;
    logic                   pd5_reg;
    logic                   pd5_next;
    logic                   pd100_reg;
    logic                   pd100_next;
    logic                   hiz_reg;
    logic                   hiz_next;
    // Status flags
    logic                   full_reg;
    logic                   full_next;
    logic                   upd_reg;
    logic                   upd_next;
    logic                   abt_reg;
    logic                   abt_next;
    logic                   busy_reg;
    logic                   busy_next;
    // Event strobes in the system clock domain
    logic                   word_event;
    logic                   fs_fall;
    logic                   fs_rise;

    // Synchronisers; stage 0 feeds only stage 1
    always_comb begin
        fs_sync_next = {fs_sync_reg[SYNC_STAGES-2:0], sync_n};
        tg_sync_next = {tg_sync_reg[1:0], lnk.toggle};
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            fs_sync_reg <= {SYNC_STAGES{1'b1}};
            tg_sync_reg <= 3'h0;
        end else begin
            fs_sync_reg <= fs_sync_next;
            tg_sync_reg <= tg_sync_next;
        end
    end

    // Rise is seen one stage later so a late word event still wins
    assign word_event = tg_sync_reg[2] ^ tg_sync_reg[1];
    assign fs_fall    = fs_sync_reg[2] & ~fs_sync_reg[1];
    assign fs_rise    = fs_sync_reg[2] & ~fs_sync_reg[3];

    // Frame tracking for status and abort reporting
    always_comb begin
        state_next = state_reg;
        abt_next   = 1'b0;
        unique case (state_reg)
            SDAC_ST_IDLE: begin
                if (fs_fall) begin
                    state_next = SDAC_ST_FRAME;
                end
            end
            SDAC_ST_FRAME: begin
                if (word_event) begin
                    state_next = SDAC_ST_DONE;
                end else if (fs_rise) begin
                    state_next = SDAC_ST_IDLE;
                    abt_next   = 1'b1;
                end
            end
            SDAC_ST_DONE: begin
                if (fs_rise) begin
                    state_next = SDAC_ST_IDLE;
                end
            end
            default: begin
                state_next = SDAC_ST_IDLE;
            end
        endcase
        busy_next = (state_next != SDAC_ST_IDLE);
    end

    // Frame tracking registers
    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= SDAC_ST_IDLE;
            abt_reg   <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            abt_reg   <= abt_next;
            busy_reg  <= busy_next;
        end
    end

    // Word decode and output control
    always_comb begin
        code_next  = code_reg;
        mode_next  = mode_reg;
        upd_next   = 1'b0;
        if (word_event) begin
            code_next = lnk.word[CODE_MSB_POS:0];
            mode_next = sdac_mode_t'(lnk.word[MODE_HI_POS:MODE_LO_POS]);
            upd_next  = 1'b1;
        end
        // Power state and termination follow the mode
        pd_next    = (mode_next != SDAC_MODE_NORMAL);
        aen_next   = ~pd_next;
        pd5_next   = 1'b0;
        pd100_next = 1'b0;
        hiz_next   = 1'b0;
        unique case (mode_next)
            SDAC_MODE_NORMAL: begin
            end
            SDAC_MODE_PD_5K: begin
                pd5_next = 1'b1;
            end
            SDAC_MODE_PD_100K: begin
                pd100_next = 1'b1;
            end
            SDAC_MODE_PD_HIZ: begin
                hiz_next = 1'b1;
            end
        endcase
        full_next = (code_next == CODE_FULL);
    end

    // Output registers, loaded together on a word event
    always_ff @(posedge clock) begin
        if (srst) begin
            code_reg  <= CODE_RESET;
            mode_reg  <= SDAC_MODE_NORMAL;
            pd_reg    <= 1'b0;
            aen_reg   <= 1'b1;
            pd5_reg   <= 1'b0;
            pd100_reg <= 1'b0;
            hiz_reg   <= 1'b0;
            full_reg  <= 1'b0;
            upd_reg   <= 1'b0;
        end else begin
            code_reg  <= code_next;
            mode_reg  <= mode_next;
            pd_reg    <= pd_next;
            aen_reg   <= aen_next;
            pd5_reg   <= pd5_next;
            pd100_reg <= pd100_next;
            hiz_reg   <= hiz_next;
            full_reg  <= full_next;
            upd_reg   <= upd_next;
        end
    end

    // Every output comes straight from a register
    assign code          = code_reg;
    assign mode          = mode_reg;
    assign power_down    = pd_reg;
    assign analog_en     = aen_reg;
    assign pulldown_5k   = pd5_reg;
    assign pulldown_100k = pd100_reg;
    assign out_hiz       = hiz_reg;
    assign code_full     = full_reg;
    assign update_pulse  = upd_reg;
    assign abort_pulse   = abt_reg;
    assign frame_busy    = busy_reg;

endmodule

// ===== sdac_pkg.sv
// Package with the constants and types of the serial converter front end
package sdac_pkg;

    localparam int          WORD_BITS      = 16;
    localparam int          CODE_BITS      = 12;
    localparam int          CNT_BITS       = 5;
    localparam logic [4:0]  CNT_LAST       = 5'h0F;
    localparam logic [4:0]  CNT_DONE       = 5'h10;
    localparam logic [4:0]  CNT_RESET      = 5'h00;
    localparam int          MODE_HI_POS    = 13;
    localparam int          MODE_LO_POS    = 12;
    localparam int          CODE_MSB_POS   = 11;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [11:0] CODE_RESET     = 12'h000;
    localparam logic [11:0] CODE_FULL      = 12'hFFF;
    localparam int          SYNC_STAGES    = 4;

    typedef enum logic [1:0] {
        SDAC_MODE_NORMAL = 2'b00,
        SDAC_MODE_PD_5K  = 2'b01,
        SDAC_MODE_PD_100K = 2'b10,
        SDAC_MODE_PD_HIZ = 2'b11
    } sdac_mode_t;

    typedef enum logic [1:0] {
        SDAC_ST_IDLE  = 2'b00,
        SDAC_ST_FRAME = 2'b01,
        SDAC_ST_DONE  = 2'b10
    } sdac_state_t;

endpackage

// ===== sdac_link_if.sv
// Interface carrying a received word and its event toggle between domains
`timescale 1ns/1ps
interface sdac_link_if;
    logic [15:0] word;
    logic        toggle;

    modport link (
        output word,
        output toggle
    );

    modport core (
        input word,
        input toggle
    );
endinterface

// ===== sdac_shift.sv
// Serial shifter running on the falling edge of the serial clock
`timescale 1ns/1ps
module sdac_shift
    import sdac_pkg::*;
(
    input  wire logic   sclk,
    input  wire logic   sync_n,
    input  wire logic   din,
    input  wire logic   srst,
    sdac_link_if.link   lnk
);

    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] shift_next;
    logic [CNT_BITS-1:0]  cnt_reg;
    logic [CNT_BITS-1:0]  cnt_next;
    logic [WORD_BITS-1:0] word_reg;
    logic [WORD_BITS-1:0] word_next;
    logic                 tog_reg;
    logic                 tog_next;

    always_comb begin
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        word_next  = word_reg;
        tog_next   = tog_reg;
        if (cnt_reg < CNT_DONE) begin
            shift_next = {shift_reg[WORD_BITS-2:0], din};
            cnt_next   = cnt_reg + 5'h01;
        end
        if (cnt_reg == CNT_LAST) begin
            word_next = {shift_reg[WORD_BITS-2:0], din};
            tog_next  = ~tog_reg;
        end
    end

    // Frame state clears whenever the frame select is high
    always_ff @(negedge sclk or posedge sync_n) begin
        if (sync_n) begin
            shift_reg <= WORD_RESET;
            cnt_reg   <= CNT_RESET;
        end else begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Captured word survives the end of the frame
    always_ff @(negedge sclk or posedge srst) begin
        if (srst) begin
            word_reg <= WORD_RESET;
            tog_reg  <= 1'b0;
        end else begin
            word_reg <= word_next;
            tog_reg  <= tog_next;
        end
    end

    assign lnk.word   = word_reg;
    assign lnk.toggle = tog_reg;

endmodule

// ===== sdac_core_sva.sv
// Checker for the serial converter front end outputs
`timescale 1ns/1ps
module sdac_core_sva
    import sdac_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 srst,
    input wire logic                 sclk,
    input wire logic                 sync_n,
    input wire logic                 din,
    input wire logic [CODE_BITS-1:0] code,
    input wire logic [1:0]           mode,
    input wire logic                 power_down,
    input wire logic                 analog_en,
    input wire logic                 pulldown_5k,
    input wire logic                 pulldown_100k,
    input wire logic                 out_hiz,
    input wire logic                 code_full,
    input wire logic                 update_pulse,
    input wire logic                 abort_pulse,
    input wire logic                 frame_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_on;
        $fell(sync_n) ##1 (!sync_n) [*5];
    endsequence
    sequence s_off;
        $rose(sync_n) ##1 sync_n [*7];
    endsequence
    property p_pd;
        power_down == (mode != 2'b00) && analog_en == !power_down;
    endproperty
    property p_term;
        out_hiz == (mode == 2'b11) && pulldown_100k == (mode == 2'b10)
            && pulldown_5k == (mode == 2'b01);
    endproperty
    property p_full;
        code_full == (code == CODE_FULL);
    endproperty
    property p_hold;
        !update_pulse |-> $stable(code) && $stable(mode);
    endproperty
    property p_upd;
        update_pulse |=> !update_pulse;
    endproperty
    property p_abt;
        abort_pulse |-> !update_pulse && $past(sync_n, 2) ##1 !abort_pulse;
    endproperty
    property p_rst;
        disable iff (1'b0) srst |=> code == CODE_RESET && mode == 2'b00 && !frame_busy;
    endproperty
    property p_busy_on;
        s_on |-> frame_busy;
    endproperty
    property p_busy_off;
        s_off |-> !frame_busy;
    endproperty
    a_pd: assert property (p_pd) else $error("power state wrong");
    a_term: assert property (p_term) else $error("termination wrong");
    a_full: assert property (p_full) else $error("full flag wrong");
    a_hold: assert property (p_hold) else $error("output moved");
    a_upd: assert property (p_upd) else $error("update too long");
    a_abt: assert property (p_abt) else $error("abort wrong");
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_busy_on: assert property (p_busy_on) else $error("busy missing");
    a_busy_off: assert property (p_busy_off) else $error("busy stuck");
endmodule
bind sdac_core sdac_core_sva sdac_core_sva_i (.clock(clock), .srst(srst), .sclk(sclk),
    .sync_n(sync_n), .din(din), .code(code), .mode(mode), .power_down(power_down),
    .analog_en(analog_en), .pulldown_5k(pulldown_5k), .pulldown_100k(pulldown_100k),
    .out_hiz(out_hiz), .code_full(code_full), .update_pulse(update_pulse),
    .abort_pulse(abort_pulse), .frame_busy(frame_busy));

// ===== sdac_host.sv
// Host model driving the three-wire serial write link
`timescale 1ns/1ps
module sdac_host (
    output logic sclk,
    output logic sync_n,
    output logic din
);
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        din = 1'b0;
    end
    task automatic write(input logic [15:0] w, input int n);
        sync_n = 1'b0;
        #7;
        for (int i = 0; i < n; i++) begin
            din = (i < 16) ? w[15-i] : ~din;
            #8 sclk = 1'b0;
            #15 sclk = 1'b1;
            #7;
        end
        #10 sync_n = 1'b1;
        din = 1'b0;
        #400;
    endtask
endmodule

// ===== sdac_core_test.sv
// Self-checking testbench for the serial converter front end
`timescale 1ns/1ps
module sdac_core_test;
    import sdac_pkg::*;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        sclk;
    logic        sync_n;
    logic        din;
    logic [11:0] code;
    logic [1:0]  mode;
    logic        power_down;
    logic        analog_en;
    logic        pd5;
    logic        pd100;
    logic        hiz;
    logic        full;
    logic        upd;
    logic        abt;
    logic        busy;
    int          upd_cnt = 0;
    int          abt_cnt = 0;
    int          busy_cnt = 0;
    logic [11:0] cv [4] = '{12'hFFF, 12'h800, 12'h001, 12'hA5C};
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    sdac_host sdac_host_i (.sclk(sclk), .sync_n(sync_n), .din(din));
    sdac_core sdac_core_i (.clock(clock), .srst(srst), .sclk(sclk), .sync_n(sync_n),
        .din(din), .code(code), .mode(mode), .power_down(power_down), .analog_en(analog_en),
        .pulldown_5k(pd5), .pulldown_100k(pd100), .out_hiz(hiz), .code_full(full),
        .update_pulse(upd), .abort_pulse(abt), .frame_busy(busy));
    initial forever #20 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (upd === 1'b1) upd_cnt++;
        if (abt === 1'b1) abt_cnt++;
        if (busy === 1'b1) busy_cnt++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [15:0] w, input int n);
        int u0;
        int a0;
        int b0;
        u0 = upd_cnt;
        a0 = abt_cnt;
        b0 = busy_cnt;
        sdac_host_i.write(w, n);
        @(posedge clock);
        #1;
        chk("update", (n >= 16) ? 16'h0001 : 16'h0000, 16'(upd_cnt - u0));
        chk("abort", (n < 16) ? 16'h0001 : 16'h0000, 16'(abt_cnt - a0));
        chk("busy", 16'h0001, {15'h0, busy_cnt > b0});
        chk("idle", 16'h0000, {15'h0, busy});
    endtask
    task automatic chk_out(input logic [11:0] c, input logic [1:0] m);
        logic [15:0] t_exp;
        t_exp = {11'h0, m == 2'b00, m != 2'b00, m == 2'b01, m == 2'b10, m == 2'b11};
        chk("code", {4'h0, c}, {4'h0, code});
        chk("mode", {14'h0, m}, {14'h0, mode});
        chk("term", t_exp, {11'h0, analog_en, power_down, pd5, pd100, hiz});
        chk("full", {15'h0, c == CODE_FULL}, {15'h0, full});
    endtask
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
        chk_out(12'h000, 2'b00);
        for (int m = 0; m < 4; m++) begin
            send({~2'(m), 2'(m), cv[m]}, 16);
            chk_out(cv[m], 2'(m));
        end
        send(16'h0123, 15);
        chk_out(cv[3], 2'b11);
        send(16'h2ABC, 20);
        chk_out(12'hABC, 2'b10);
        repeat (200) @(posedge clock);
        #1;
        chk_out(12'hABC, 2'b10);
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        #1;
        chk_out(12'h000, 2'b00);
        repeat (4) @(posedge clock);
        #1;
        send(16'h3FFF, 9);
        chk_out(12'h000, 2'b00);
        send(16'h15A3, 16);
        chk_out(12'h5A3, 2'b01);
        final_report();
    end
endmodule
